// File: core/tmz_div_if.sv
// Interface between the top and the shared divider
`timescale 1ns/1ps
interface tmz_div_if;
    logic tick; // Event into the divider
    logic clear; // Divider clear
    logic [2:0] rate; // Rate code
    logic owner; // Owner select
    logic out; // One-cycle output pulse
    modport top (output tick, output clear, output rate, output owner, input out);
    modport div (input tick, input clear, input rate, input owner, output out);
endinterface : tmz_div_if

// File: core/tmz_divider.sv
// Shared 8-bit divider for timer prescale and watchdog postscale
`timescale 1ns/1ps
module tmz_divider
    import tmz_pkg::*;
(
    input wire logic clk_in, // Clock
    input wire logic srst_in, // Sync reset
    input wire logic ce_in, // Clock enable
    tmz_div_if.div d // Divider port
);
    logic [7:0] count_q;
    logic [7:0] limit;
    logic [3:0] shift;
    // ==================================================
    // Ratio: timer 2^(rate+1), watchdog 2^rate
    always_comb begin
        shift = {1'b0, d.rate} + ((d.owner == TMZ_OWNER_TIMER) ? 4'h1 : 4'h0); // see RL3
        limit = 8'(({1'b0, TMZ_ONES8} + 9'h1 >> (4'h8 - shift)) - 9'h1);
    end
    // Count, hidden from software; one counter for both owners
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            count_q <= TMZ_ZERO8;
        end else if (ce_in) begin
            if (d.clear) begin
                count_q <= TMZ_ZERO8; // see RL5 see RL6
            end else if (d.tick) begin
                count_q <= (count_q >= limit) ? TMZ_ZERO8 : count_q + 8'h1; // see RL1
            end
        end
    end
    assign d.out = d.tick && !d.clear && (count_q >= limit); // see RL1
endmodule : tmz_divider

// File: core/tmz_pkg.sv
// Package of register map, field positions and constants for the timer with shared divider
package tmz_pkg;
    // ==================================================
    // Register map
    localparam logic [7:0] TMZ_ADDR_TIMER0_COUNT = 8'h01;
    localparam logic [7:0] TMZ_ADDR_INTERRUPT_CONTROL = 8'h0b;
    localparam logic [7:0] TMZ_ADDR_TIMER_OPTION = 8'h81;
    localparam logic [7:0] TMZ_ADDR_PIN_DIRECTION = 8'h85;
    localparam logic [7:0] TMZ_ADDR_IRQ_STATUS = 8'hf0;
    localparam logic [7:0] TMZ_ADDR_IRQ_MASK = 8'hf1;
    localparam logic [7:0] TMZ_ADDR_WDT_CLEAR = 8'hf2;
    // ==================================================
    // Reset values
    localparam logic [7:0] TMZ_RST_OPTION = 8'hff;
    localparam logic [7:0] TMZ_RST_INTCTL = 8'h00;
    localparam logic [7:0] TMZ_RST_PINDIR = 8'h3f;
    localparam logic [7:0] TMZ_PINDIR_MASK = 8'h3f;
    localparam logic [7:0] TMZ_ZERO8 = 8'h00;
    localparam logic [7:0] TMZ_ONES8 = 8'hff;
    // ==================================================
    // Field positions
    localparam int TMZ_OPT_SOURCE = 5;
    localparam int TMZ_OPT_EDGE = 4;
    localparam int TMZ_OPT_ASSIGN = 3;
    localparam int TMZ_OPT_RATE_HI = 2;
    localparam int TMZ_INT_ENABLE = 5;
    localparam int TMZ_INT_FLAG = 2;
    localparam int TMZ_ST_OVERFLOW = 0;
    localparam int TMZ_ST_WDT_EXPIRE = 1;
    // ==================================================
    // Timing
    localparam logic [1:0] TMZ_WRITE_HOLD_CYCLES = 2'h2;
    localparam int TMZ_WDT_BASE_WIDTH = 8;
    // Divider owner
    typedef enum logic [0:0] {
        TMZ_OWNER_TIMER = 1'b0,
        TMZ_OWNER_WDT = 1'b1
    } tmz_owner_type;
endpackage : tmz_pkg

// File: core/tmz_sync.sv
// Two-flop synchroniser with edge detection behind it
`timescale 1ns/1ps
module tmz_sync (
    input wire logic clk_in, // Clock
    input wire logic srst_in, // Sync reset
    input wire logic ce_in, // Clock enable
    input wire logic async_in, // Pin level
    output logic rise_out, // Rising edge pulse
    output logic fall_out // Falling edge pulse
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    // ==================================================
    // Synchroniser chain; only the second and third flops feed logic
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else if (ce_in) begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    assign rise_out = ce_in && s2_q && !s3_q;
    assign fall_out = ce_in && !s2_q && s3_q;
endmodule : tmz_sync

// File: core/tmz_timer0.sv
// Timer0 with a divider shared with the watchdog, register port and interrupt
//
// Function
// RL1: One 8-bit divider serves either the timer as prescaler or the watchdog as postscaler, never both.
// RL2: Assignment bit 0 gives the divider to the timer, 1 gives it to the watchdog.
// RL3: Rate code selects timer ratio 1:2..1:256 or watchdog ratio 1:1..1:128.
// RL4: The divider count is never visible to or writable by software.
// RL5: Writing the timer count while the divider serves the timer clears the divider.
// RL6: A watchdog clear while the divider serves the watchdog clears divider and watchdog counter.
// RL7: The assignment may change at any time without reset or halt.
// RL8: Software moving the divider to the watchdog clears watchdog, writes timer count, then writes option.
// RL9: For a wanted watchdog rate of 000 or 001 software writes an interim higher rate and clears first.
// RL10: Software moving the divider to the timer clears the watchdog first, then writes option.
// RL11: With source bit clear the timer counts each cycle, or each divider period when assigned.
// RL12: With source bit set the timer counts pin edges, rising when edge bit clear, falling when set.
// RL13: Wrap from FFh to 00h sets the overflow flag, which software clears; enable bit gates it.
// RL14: After a timer count write, increments are suppressed for two cycles.
// RL15: With the divider at the watchdog the timer counts every source event undivided.
// RL16: The option register resets to all ones.
`timescale 1ns/1ps
module tmz_timer0
    import tmz_pkg::*;
#(
    parameter int WDT_BASE_WIDTH = TMZ_WDT_BASE_WIDTH // Watchdog counter width
) (
    input wire logic core_clk_in, // 125 MHz clock
    input wire logic srst_in, // Sync reset, active high
    input wire logic ce_in, // Clock enable
    input wire logic [7:0] addr_in, // Register address
    input wire logic [7:0] wdata_in, // Write data
    input wire logic wr_in, // Write strobe
    input wire logic rd_in, // Read strobe
    input wire logic ext_count_pin_in, // External count pin
    output logic [7:0] rdata_out, // Read data, cycle after strobe
    output logic irq_out, // Level interrupt
    output logic overflow_flag_out, // Timer overflow flag
    output logic wdt_reset_out // Watchdog expiry pulse
);
    // ==================================================
    // Parameter check
    initial begin
        if (WDT_BASE_WIDTH < 1 || WDT_BASE_WIDTH > 24) begin
            $error("tmz_timer0: WDT_BASE_WIDTH out of range");
        end
    end

    // ==================================================
    // Registers and wires
    logic [7:0] timer0_count_q;
    logic [7:0] option_q;
    logic [7:0] intctl_q;
    logic [7:0] pindir_q;
    logic [7:0] irq_status_q;
    logic [7:0] irq_mask_q;
    logic [7:0] rdata_q;
    logic irq_q;
    logic wdt_rst_q;
    logic [1:0] hold_q;
    logic [WDT_BASE_WIDTH-1:0] wdt_base_q;
    logic wr_count;
    logic wr_option;
    logic wr_intctl;
    logic wdt_clear;
    logic rd_status;
    logic pin_rise;
    logic pin_fall;
    logic src_event;
    logic wdt_event;
    logic timer_inc;
    logic wrap;
    logic owner_wdt;
    tmz_div_if div_bus ();

    // ==================================================
    // Address decode
    assign wr_count = wr_in && (addr_in == TMZ_ADDR_TIMER0_COUNT);
    assign wr_option = wr_in && (addr_in == TMZ_ADDR_TIMER_OPTION);
    assign wr_intctl = wr_in && (addr_in == TMZ_ADDR_INTERRUPT_CONTROL);
    assign wdt_clear = wr_in && (addr_in == TMZ_ADDR_WDT_CLEAR);
    assign rd_status = rd_in && (addr_in == TMZ_ADDR_IRQ_STATUS);
    assign owner_wdt = option_q[TMZ_OPT_ASSIGN]; // see RL2

    // ==================================================
    // External pin synchroniser and edge detect
    tmz_sync u_sync (
        .clk_in(core_clk_in),
        .srst_in(srst_in),
        .ce_in(ce_in),
        .async_in(ext_count_pin_in),
        .rise_out(pin_rise),
        .fall_out(pin_fall)
    );

    // Source event: each cycle or selected pin edge
    always_comb begin
        if (option_q[TMZ_OPT_SOURCE]) begin
            src_event = option_q[TMZ_OPT_EDGE] ? pin_fall : pin_rise; // see RL12
        end else begin
            src_event = ce_in; // see RL11
        end
    end

    // ==================================================
    // Shared divider: tick comes from the owner's event stream
    assign wdt_event = ce_in && (wdt_base_q == {WDT_BASE_WIDTH{1'b1}});
    assign div_bus.owner = owner_wdt; // see RL1 see RL7
    assign div_bus.rate = option_q[TMZ_OPT_RATE_HI:0]; // see RL3
    assign div_bus.tick = owner_wdt ? wdt_event : src_event;
    assign div_bus.clear = owner_wdt ? wdt_clear : wr_count; // see RL5 see RL6

    tmz_divider u_div (
        .clk_in(core_clk_in),
        .srst_in(srst_in),
        .ce_in(ce_in),
        .d(div_bus)
    );

    // Timer increment: divided when assigned, direct otherwise
    assign timer_inc = (hold_q == 2'h0) && !wr_count
        && (owner_wdt ? src_event : div_bus.out); // see RL11 see RL15 see RL14
    assign wrap = timer_inc && (timer0_count_q == TMZ_ONES8); // see RL13

    // ==================================================
    // Timer count register
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            timer0_count_q <= TMZ_ZERO8;
        end else if (ce_in) begin
            if (wr_count) begin
                timer0_count_q <= wdata_in;
            end else if (timer_inc) begin
                timer0_count_q <= timer0_count_q + 8'h1;
            end
        end
    end

    // Increment hold after a count write
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            hold_q <= 2'h0;
        end else if (ce_in) begin
            if (wr_count) begin
                hold_q <= TMZ_WRITE_HOLD_CYCLES; // see RL14
            end else if (hold_q != 2'h0) begin
                hold_q <= hold_q - 2'h1;
            end
        end
    end

    // ==================================================
    // Option register; all ones at reset, writable any time
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            option_q <= TMZ_RST_OPTION; // see RL16
        end else if (ce_in && wr_option) begin
            option_q <= wdata_in; // see RL7
        end
    end

    // Pin direction register; upper bits unimplemented
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            pindir_q <= TMZ_RST_PINDIR;
        end else if (ce_in && wr_in && addr_in == TMZ_ADDR_PIN_DIRECTION) begin
            pindir_q <= wdata_in & TMZ_PINDIR_MASK;
        end
    end

    // Interrupt control: flag set by wrap wins over a software write
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            intctl_q <= TMZ_RST_INTCTL;
        end else if (ce_in) begin
            if (wr_intctl) begin
                intctl_q <= wdata_in;
            end
            if (wrap) begin
                intctl_q[TMZ_INT_FLAG] <= 1'b1; // see RL13
            end
        end
    end

    // ==================================================
    // Watchdog base counter; cleared by the clear command
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            wdt_base_q <= '0;
        end else if (ce_in) begin
            if (wdt_clear) begin
                wdt_base_q <= '0; // see RL6
            end else begin
                wdt_base_q <= wdt_base_q + 1'b1;
            end
        end
    end

    // Watchdog expiry: postscaler output or base rollover undivided
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            wdt_rst_q <= 1'b0;
        end else if (ce_in) begin
            wdt_rst_q <= owner_wdt ? div_bus.out : (wdt_event && !wdt_clear);
        end
    end

    // ==================================================
    // Sticky status, cleared by read; set wins over clear
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            irq_status_q <= TMZ_ZERO8;
        end else if (ce_in) begin
            if (rd_status) begin
                irq_status_q <= TMZ_ZERO8;
            end
            if (wrap) begin
                irq_status_q[TMZ_ST_OVERFLOW] <= 1'b1;
            end
            if (owner_wdt ? div_bus.out : (wdt_event && !wdt_clear)) begin
                irq_status_q[TMZ_ST_WDT_EXPIRE] <= 1'b1;
            end
        end
    end

    // Mask register
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            irq_mask_q <= TMZ_ZERO8;
        end else if (ce_in && wr_in && addr_in == TMZ_ADDR_IRQ_MASK) begin
            irq_mask_q <= wdata_in;
        end
    end

    // Interrupt output: masked sticky status or enabled overflow flag
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            irq_q <= 1'b0;
        end else if (ce_in) begin
            irq_q <= (|(irq_status_q & irq_mask_q))
                || (intctl_q[TMZ_INT_FLAG] && intctl_q[TMZ_INT_ENABLE]); // see RL13
        end
    end

    // ==================================================
    // Read port; the divider count has no address
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            rdata_q <= TMZ_ZERO8;
        end else if (ce_in) begin
            rdata_q <= TMZ_ZERO8;
            if (rd_in) begin
                unique case (addr_in)
                    TMZ_ADDR_TIMER0_COUNT: rdata_q <= timer0_count_q;
                    TMZ_ADDR_INTERRUPT_CONTROL: rdata_q <= intctl_q;
                    TMZ_ADDR_TIMER_OPTION: rdata_q <= option_q;
                    TMZ_ADDR_PIN_DIRECTION: rdata_q <= pindir_q;
                    TMZ_ADDR_IRQ_STATUS: rdata_q <= irq_status_q;
                    TMZ_ADDR_IRQ_MASK: rdata_q <= irq_mask_q;
                    default: rdata_q <= TMZ_ZERO8; // see RL4
                endcase
            end
        end
    end

    // Outputs from flops
    assign rdata_out = rdata_q;
    assign irq_out = irq_q;
    assign overflow_flag_out = intctl_q[TMZ_INT_FLAG];
    assign wdt_reset_out = wdt_rst_q;
endmodule : tmz_timer0

// File: dv/timer0_shared_prescaler_tb_top.sv
// Self-checking bench for the timer with shared divider
`timescale 1ns/1ps
module timer0_shared_prescaler_tb_top;
    import tmz_pkg::*;
    // ==================================================
    // Ports and bench state
    logic core_clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic ce_in = 1'b1; // Always running
    logic [7:0] addr_in = 8'h00;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic ext_count_pin_in = 1'b0;
    logic [7:0] rdata_out;
    logic irq_out;
    logic overflow_flag_out;
    logic wdt_reset_out;
    int failures = 0;
    int samples_checked = 0;
    int seed = 32'h6057;
    int gap_n;
    logic [7:0] v;
    logic [7:0] x;
    // Register model after reset, one unmapped place among them
    logic [7:0] m_reg[logic [7:0]] = '{8'h01: 8'h00, 8'h0b: 8'h00, 8'h81: 8'hff, 8'h85: 8'h3f, 8'hf1: 8'h00, 8'h40: 8'h00};
    tmz_timer0 #(.WDT_BASE_WIDTH(4)) dut (
        .core_clk_in(core_clk_in), .srst_in(srst_in), .ce_in(ce_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .ext_count_pin_in(ext_count_pin_in),
        .rdata_out(rdata_out), .irq_out(irq_out), .overflow_flag_out(overflow_flag_out),
        .wdt_reset_out(wdt_reset_out));
    // 125 MHz clock
    always #4 core_clk_in = ~core_clk_in;
    // ==================================================
    // Tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk_in);
    endtask : idle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge core_clk_in);
        wr_in <= 1'b0;
        // One edge passes so a following write never re-raises the strobe in this step
        @(posedge core_clk_in);
    endtask : wr
    // Read data is taken in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge core_clk_in);
        rd_in <= 1'b0;
        @(negedge core_clk_in);
        d = rdata_out;
        @(posedge core_clk_in);
    endtask : rd
    task automatic toggle(input int n);
        repeat (n) begin
            idle(6);
            ext_count_pin_in <= ~ext_count_pin_in;
        end
        idle(6);
    endtask : toggle
    // Cycles up to the next watchdog pulse
    task automatic gap(output int n);
        n = 0;
        do begin
            @(negedge core_clk_in);
            n++;
        end while (wdt_reset_out !== 1'b1 && n < 3000);
    endtask : gap
    task automatic stop_test;
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test
    // Hang guard
    initial begin
        #100000;
        failures++;
        stop_test();
    end
    // ==================================================
    // Main sequence
    initial begin
        idle(5);
        srst_in <= 1'b0;
        rd(TMZ_ADDR_TIMER_OPTION, v);
        check(v, TMZ_RST_OPTION);
        foreach (m_reg[a]) begin
            rd(a, v);
            check(v, m_reg[a]);
        end
        wr(TMZ_ADDR_PIN_DIRECTION, TMZ_ONES8);
        wr(8'h40, TMZ_ONES8);
        rd(TMZ_ADDR_PIN_DIRECTION, v);
        check(v, TMZ_PINDIR_MASK);
        rd(8'h40, v);
        check(v, TMZ_ZERO8);
        x = 8'($random(seed));
        wr(TMZ_ADDR_TIMER_OPTION, x);
        rd(TMZ_ADDR_TIMER_OPTION, v);
        check(v, x);
        // Undivided internal count around a count write
        wr(TMZ_ADDR_TIMER_OPTION, 8'h0f);
        for (int k = 1; k <= 6; k++) begin
            x = 8'($random(seed)) & 8'h7f;
            wr(TMZ_ADDR_TIMER0_COUNT, x);
            idle(k - 1);
            rd(TMZ_ADDR_TIMER0_COUNT, v);
            check(v, x + 8'((k > 2) ? k - 2 : 0));
        end
        // Overflow flag, enable, status and mask
        wr(TMZ_ADDR_INTERRUPT_CONTROL, 8'h20);
        wr(TMZ_ADDR_TIMER0_COUNT, 8'hfa);
        idle(12);
        check(8'({overflow_flag_out, irq_out}), 8'h03);
        rd(TMZ_ADDR_INTERRUPT_CONTROL, v);
        check(v, 8'h24);
        rd(TMZ_ADDR_IRQ_STATUS, v);
        check(v & 8'h01, 8'h01);
        wr(TMZ_ADDR_INTERRUPT_CONTROL, 8'h00);
        wr(TMZ_ADDR_IRQ_MASK, 8'h01);
        wr(TMZ_ADDR_TIMER0_COUNT, 8'hfa);
        idle(12);
        check(8'({overflow_flag_out, irq_out}), 8'h03);
        rd(TMZ_ADDR_IRQ_STATUS, v);
        idle(2);
        check(8'({overflow_flag_out, irq_out}), 8'h02);
        wr(TMZ_ADDR_IRQ_MASK, 8'h00);
        wr(TMZ_ADDR_TIMER0_COUNT, 8'hfa);
        idle(12);
        check(8'(irq_out), 8'h00);
        // Software write of the flag bit, then its clear
        wr(TMZ_ADDR_INTERRUPT_CONTROL, 8'h00);
        wr(TMZ_ADDR_INTERRUPT_CONTROL, 8'h04);
        rd(TMZ_ADDR_INTERRUPT_CONTROL, v);
        check(v, 8'h04);
        wr(TMZ_ADDR_INTERRUPT_CONTROL, 8'h00);
        rd(TMZ_ADDR_INTERRUPT_CONTROL, v);
        check(v, 8'h00);
        // Divider moved to the watchdog and back, for rates 0 to 2
        wr(TMZ_ADDR_IRQ_MASK, 8'h02);
        for (int r = 0; r < 3; r++) begin
            wr(TMZ_ADDR_WDT_CLEAR, TMZ_ZERO8);
            wr(TMZ_ADDR_TIMER0_COUNT, TMZ_ZERO8);
            if (r < 2) begin
                wr(TMZ_ADDR_TIMER_OPTION, 8'h0f);
                wr(TMZ_ADDR_WDT_CLEAR, TMZ_ZERO8);
            end
            wr(TMZ_ADDR_TIMER_OPTION, 8'(8'h08 + r));
            gap(gap_n);
            gap(gap_n);
            check(8'(gap_n), 8'(16 << r));
            idle(3);
            check(8'(irq_out), 8'h01);
            rd(TMZ_ADDR_IRQ_STATUS, v);
            check(v & 8'h02, 8'h02);
            wr(TMZ_ADDR_WDT_CLEAR, TMZ_ZERO8);
            wr(TMZ_ADDR_TIMER_OPTION, 8'(r));
            wr(TMZ_ADDR_TIMER0_COUNT, TMZ_ZERO8);
            idle(20 * (2 << r));
            rd(TMZ_ADDR_TIMER0_COUNT, v);
            check(8'(v inside {[8'd18:8'd20]}), 8'h01);
        end
        // Pin edges, rising then falling
        wr(TMZ_ADDR_TIMER_OPTION, 8'h2f);
        wr(TMZ_ADDR_TIMER0_COUNT, TMZ_ZERO8);
        toggle(9);
        rd(TMZ_ADDR_TIMER0_COUNT, v);
        check(v, 8'h05);
        wr(TMZ_ADDR_TIMER_OPTION, 8'h3f);
        wr(TMZ_ADDR_TIMER0_COUNT, TMZ_ZERO8);
        toggle(7);
        rd(TMZ_ADDR_TIMER0_COUNT, v);
        check(v, 8'h04);
        stop_test();
    end
endmodule : timer0_shared_prescaler_tb_top

// File: dv/tmz_timer0_asserts.sv
// Port-level checks for the timer with shared divider
`timescale 1ns/1ps
module tmz_timer0_asserts
    import tmz_pkg::*;
#(
    parameter int WDT_BASE_WIDTH = TMZ_WDT_BASE_WIDTH // Watchdog counter width
) (
    input wire logic core_clk_in, // Clock
    input wire logic srst_in, // Sync reset
    input wire logic ce_in, // Clock enable
    input wire logic [7:0] addr_in, // Address
    input wire logic [7:0] wdata_in, // Write data
    input wire logic wr_in, // Write strobe
    input wire logic rd_in, // Read strobe
    input wire logic ext_count_pin_in, // Count pin
    input wire logic [7:0] rdata_out, // Read data
    input wire logic irq_out, // Interrupt
    input wire logic overflow_flag_out, // Overflow flag
    input wire logic wdt_reset_out // Watchdog pulse
);
    // ==================================================
    // Clock for every property; reset disables all but a_reset_quiet
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (srst_in);
    a_reset_quiet: assert property (disable iff (1'b0) srst_in |=> !irq_out && !overflow_flag_out && !wdt_reset_out)
        else $error("outputs active after reset");
    a_option_reset_read: assert property ($fell(srst_in) && rd_in && addr_in == TMZ_ADDR_TIMER_OPTION |=> rdata_out == TMZ_RST_OPTION)
        else $error("option not all ones after reset");
    a_rdata_idle_zero: assert property (!rd_in |=> rdata_out == TMZ_ZERO8)
        else $error("read data without read");
    a_write_hold_first: assert property (wr_in && addr_in == TMZ_ADDR_TIMER0_COUNT ##1 !wr_in ##1 !wr_in ##1 rd_in && addr_in == TMZ_ADDR_TIMER0_COUNT |=> rdata_out == $past(wdata_in, 4))
        else $error("count moved inside the hold after write");
    a_write_hold_second: assert property (wr_in && addr_in == TMZ_ADDR_TIMER0_COUNT ##1 !wr_in ##1 rd_in && addr_in == TMZ_ADDR_TIMER0_COUNT |=> rdata_out == $past(wdata_in, 3))
        else $error("count moved two cycles after write");
    a_flag_stays_set: assert property (overflow_flag_out && !(wr_in && addr_in == TMZ_ADDR_INTERRUPT_CONTROL) && !$past(wr_in && addr_in == TMZ_ADDR_INTERRUPT_CONTROL) |=> overflow_flag_out)
        else $error("overflow flag cleared by itself");
    a_flag_write_set: assert property (wr_in && addr_in == TMZ_ADDR_INTERRUPT_CONTROL && wdata_in[TMZ_INT_FLAG] |-> ##[1:2] overflow_flag_out)
        else $error("flag write not seen");
    a_irq_fall_cause: assert property ($fell(irq_out) |-> $past(rd_in || wr_in) || $past(rd_in || wr_in, 2))
        else $error("interrupt dropped without access");
    a_wdt_pulse_gap: assert property (wdt_reset_out |=> !wdt_reset_out [*8])
        else $error("watchdog pulses too close");
    a_wdt_clear_quiet: assert property (wr_in && addr_in == TMZ_ADDR_WDT_CLEAR |-> ##2 !wdt_reset_out [*8])
        else $error("watchdog expired right after clear");
endmodule : tmz_timer0_asserts

bind tmz_timer0 tmz_timer0_asserts #(.WDT_BASE_WIDTH(WDT_BASE_WIDTH)) u_tmz_chk (
    .core_clk_in(core_clk_in), .srst_in(srst_in), .ce_in(ce_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .ext_count_pin_in(ext_count_pin_in),
    .rdata_out(rdata_out), .irq_out(irq_out), .overflow_flag_out(overflow_flag_out),
    .wdt_reset_out(wdt_reset_out));
